// *** hw/motor_ctrl_pkg.sv ***
package motor_ctrl_pkg;

   // Register offsets on the configuration port
   localparam logic [3:0] OFS_WRITE_LOCK = 4'h3;
   localparam logic [3:0] OFS_IF_MODE = 4'h4;
   localparam logic [3:0] OFS_SUPPLY_REP = 4'h5;
   localparam logic [3:0] OFS_OC_DRV = 4'h6;

   // Reset values
   localparam logic [7:0] RST_WRITE_LOCK = 8'h00;
   localparam logic [7:0] RST_IF_MODE = 8'h80;
   localparam logic [7:0] RST_SUPPLY_REP = 8'h46;
   localparam logic [7:0] RST_OC_DRV = 8'h10;

   // Write-lock field and its codes
   localparam int LOCK_LSB = 0;
   localparam int LOCK_W = 3;
   localparam logic [2:0] LOCK_CODE_OPEN = 3'h3;
   localparam logic [2:0] LOCK_CODE_CLOSE = 3'h6;

   // Interface and mode register fields
   localparam int DATA_OUT_DRIVE_BIT = 5;
   localparam int SLEW_LSB = 3;
   localparam int MODE_SYNC_BIT = 2;
   localparam int MODE_DIGITAL_BIT = 1;
   localparam int FAULT_CLEAR_BIT = 0;

   // Supply and reporting register fields; bit 7 reads as zero
   localparam logic [7:0] SUPPLY_REP_RW_MASK = 8'h7f;
   localparam int FULL_DUTY_40K_BIT = 4;
   localparam int OV_THRESH_BIT = 3;
   localparam int OV_ENABLE_BIT = 2;
   localparam int SERIAL_MASK_BIT = 1;
   localparam int THERM_REP_BIT = 0;

   // Overcurrent and driver register fields
   localparam int HIZ_FORCE_BIT = 7;
   localparam int CLEAR_ON_CYCLE_BIT = 6;
   localparam int DEGLITCH_LSB = 4;
   localparam int RETRY_WAIT_BIT = 3;
   localparam int TRIP_LEVEL_BIT = 2;
   localparam int RESP_MODE_LSB = 0;
   localparam logic [1:0] RESP_LATCHED = 2'h0;
   localparam logic [1:0] RESP_RETRY = 2'h1;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEGLITCH_0_NS = 200;
   localparam int DEGLITCH_1_NS = 600;
   localparam int DEGLITCH_2_NS = 1200;
   localparam int DEGLITCH_3_NS = 1600;
   localparam int RETRY_SHORT_MS = 5;
   localparam int RETRY_LONG_MS = 500;
   localparam int NS_PER_MS = 1000000;
   localparam int DEG_CNT_W = 9;
   localparam int RETRY_CNT_W = 27;

   // Least times round up to whole cycles
   localparam int DEGLITCH_0_CYC =
      (DEGLITCH_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGLITCH_1_CYC =
      (DEGLITCH_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGLITCH_2_CYC =
      (DEGLITCH_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGLITCH_3_CYC =
      (DEGLITCH_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_SHORT_CYC =
      (RETRY_SHORT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_LONG_CYC =
      (RETRY_LONG_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Configuration port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Analog and pin events seen by the block
   typedef struct packed {
      logic overcurrent;
      logic overvoltage;
      logic thermal_warning;
      logic serial_fault;
      logic pwm_in;
   } sense_t;

   // Settings steering the power stage
   typedef struct packed {
      logic data_out_push_pull;
      logic [1:0] slew_select;
      logic sync_rectify;
      logic digital_hall;
      logic full_duty_40k;
      logic ov_thresh_22v;
      logic ov_protect_en;
      logic trip_level_13a;
      logic outputs_hiz;
   } drive_cfg_t;

   // Block state
   typedef struct packed {
      logic [7:0] if_mode;
      logic [7:0] supply_rep;
      logic [7:0] oc_drv;
      logic [2:0] lock_code;
      logic locked;
      logic fault_clear;
      logic [DEG_CNT_W-1:0] deg_cnt;
      logic oc_fault;
      logic [RETRY_CNT_W-1:0] retry_cnt;
      logic ov_fault;
      logic serial_fault;
      logic pwm_prev;
      logic fault_out_n;
      logic rvalid;
      logic [7:0] rdata;
   } state_t;

   function automatic logic [DEG_CNT_W-1:0] deglitch_cycles(
      input logic [1:0] sel);
      case (sel)
         2'h0: deglitch_cycles = DEG_CNT_W'(DEGLITCH_0_CYC);
         2'h1: deglitch_cycles = DEG_CNT_W'(DEGLITCH_1_CYC);
         2'h2: deglitch_cycles = DEG_CNT_W'(DEGLITCH_2_CYC);
         default: deglitch_cycles = DEG_CNT_W'(DEGLITCH_3_CYC);
      endcase
   endfunction : deglitch_cycles

endpackage : motor_ctrl_pkg

// *** hw/motor_driver_control_regs.sv ***
// Notes on behaviour
// - Lock field code 011b unlocks all registers for later writes.
// - Lock code 110b locks; then only lock-field writes are taken.
// - Other lock codes keep the present locked or unlocked state.
// - Interface bit 5 picks data-out drive: 0 open-drain, 1 push-pull.
// - Bits 4-3 select edge rate 25, 50, 125 or 200 V/us.
// - Mode bits 2-1: high bit synchronous rectify, low bit digital Hall.
// - Writing 1 to bit 0 clears latched faults; bit reads back 0.
// - Supply bit 4 sets full-duty PWM: 0 is 20 kHz, 1 is 40 kHz.
// - Supply bit 3 sets overvoltage threshold: 0 is 34 V, 1 is 22 V.
// - Supply bit 2 enables overvoltage protection; resets to 1.
// - Supply bit 1 set masks serial faults from fault pin; resets 1.
// - Supply bit 0 set reports thermal warnings on fault pin; resets 0.
// - Driver bit 7 set forces all output switches to high impedance.
// - Driver bit 6 set clears overcurrent on each new PWM input cycle.
// - Bits 5-4 pick deglitch 0.2, 0.6, 1.2 or 1.6 us; reset code 1.
// - Driver bit 3 picks retry wait: 0 is 5 ms, 1 is 500 ms.
// - Driver bit 2 picks overcurrent trip level: 0 is 9 A, 1 is 13 A.
// - Mode bits 1-0: 0 latched, 1 auto-retry; host never writes 2, 3.
module motor_driver_control_regs #(
   parameter int RETRY_SHORT_CYCLES = motor_ctrl_pkg::RETRY_SHORT_CYC,
   parameter int RETRY_LONG_CYCLES = motor_ctrl_pkg::RETRY_LONG_CYC
)(
   input wire logic CLK,
   input wire logic RST_B,
   input wire motor_ctrl_pkg::reg_req_t REG_REQ,
   input wire motor_ctrl_pkg::sense_t SENSE,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   output motor_ctrl_pkg::drive_cfg_t DRIVE_CFG,
   output logic LOCKED,
   output logic FAULT_CLEAR_PULSE,
   output logic OC_FAULT,
   output logic OV_FAULT,
   output logic SERIAL_FAULT,
   output logic FAULT_OUT_N
);

   motor_ctrl_pkg::state_t st_reg;
   motor_ctrl_pkg::state_t st_next;

   logic wr_open;
   logic [motor_ctrl_pkg::DEG_CNT_W-1:0] deg_limit;
   logic [motor_ctrl_pkg::RETRY_CNT_W-1:0] retry_limit;
   logic oc_trip;
   logic cycle_start;
   logic retry_done;
   logic [2:0] lock_wdata;
   logic fault_any;

   always_comb
   begin
      st_next = st_reg;
      lock_wdata = REG_REQ.wdata[motor_ctrl_pkg::LOCK_LSB +:
         motor_ctrl_pkg::LOCK_W];

      // Register writes; lock field always reachable
      wr_open = REG_REQ.wr && !st_reg.locked;
      st_next.fault_clear = 1'b0;
      if (REG_REQ.wr && REG_REQ.addr == motor_ctrl_pkg::OFS_WRITE_LOCK)
      begin
         st_next.lock_code = lock_wdata;
         if (lock_wdata == motor_ctrl_pkg::LOCK_CODE_OPEN)
         begin
            st_next.locked = 1'b0;
         end
         else if (lock_wdata == motor_ctrl_pkg::LOCK_CODE_CLOSE)
         begin
            st_next.locked = 1'b1;
         end
         // Any other code leaves the lock as it is
      end
      if (wr_open)
      begin
         case (REG_REQ.addr)
            motor_ctrl_pkg::OFS_IF_MODE:
            begin
               st_next.if_mode = REG_REQ.wdata;
               // Command bit is never stored
               st_next.if_mode[motor_ctrl_pkg::FAULT_CLEAR_BIT] = 1'b0;
               st_next.fault_clear =
                  REG_REQ.wdata[motor_ctrl_pkg::FAULT_CLEAR_BIT];
            end
            motor_ctrl_pkg::OFS_SUPPLY_REP:
            begin
               // Top bit is read-as-zero
               st_next.supply_rep =
                  REG_REQ.wdata & motor_ctrl_pkg::SUPPLY_REP_RW_MASK;
            end
            motor_ctrl_pkg::OFS_OC_DRV:
            begin
               st_next.oc_drv = REG_REQ.wdata;
            end
            default:
            begin
               st_next.oc_drv = st_reg.oc_drv;
            end
         endcase
      end

      // Read data is registered; unmapped offsets read zero
      st_next.rvalid = REG_REQ.rd;
      if (REG_REQ.rd)
      begin
         case (REG_REQ.addr)
            motor_ctrl_pkg::OFS_WRITE_LOCK:
               st_next.rdata = {5'h00, st_reg.lock_code};
            motor_ctrl_pkg::OFS_IF_MODE:
               st_next.rdata = st_reg.if_mode;
            motor_ctrl_pkg::OFS_SUPPLY_REP:
               st_next.rdata = st_reg.supply_rep;
            motor_ctrl_pkg::OFS_OC_DRV:
               st_next.rdata = st_reg.oc_drv;
            default:
               st_next.rdata = 8'h00;
         endcase
      end

      // Overcurrent deglitch: input must hold for the whole filter time
      deg_limit = motor_ctrl_pkg::deglitch_cycles(
         st_reg.oc_drv[motor_ctrl_pkg::DEGLITCH_LSB +: 2]);
      oc_trip = 1'b0;
      if (!SENSE.overcurrent)
      begin
         st_next.deg_cnt = '0;
      end
      else if (st_reg.deg_cnt + 1'b1 >= deg_limit)
      begin
         oc_trip = 1'b1;
         st_next.deg_cnt = deg_limit;
      end
      else
      begin
         st_next.deg_cnt = st_reg.deg_cnt + 1'b1;
      end

      // New PWM input cycle starts on its rising edge
      st_next.pwm_prev = SENSE.pwm_in;
      cycle_start = SENSE.pwm_in && !st_reg.pwm_prev;

      // Retry wait runs only while an auto-retry fault is held
      retry_limit = st_reg.oc_drv[motor_ctrl_pkg::RETRY_WAIT_BIT]
         ? motor_ctrl_pkg::RETRY_CNT_W'(RETRY_LONG_CYCLES)
         : motor_ctrl_pkg::RETRY_CNT_W'(RETRY_SHORT_CYCLES);
      retry_done = 1'b0;
      if (st_reg.oc_fault && st_reg.oc_drv[motor_ctrl_pkg::RESP_MODE_LSB +: 2]
         == motor_ctrl_pkg::RESP_RETRY)
      begin
         if (st_reg.retry_cnt + 1'b1 >= retry_limit)
         begin
            retry_done = 1'b1;
            st_next.retry_cnt = '0;
         end
         else
         begin
            st_next.retry_cnt = st_reg.retry_cnt + 1'b1;
         end
      end
      else
      begin
         st_next.retry_cnt = '0;
      end

      // Reserved modes 2 and 3 behave as latched; a new trip wins the clear
      if (oc_trip)
      begin
         st_next.oc_fault = 1'b1;
      end
      else if (st_reg.fault_clear || retry_done)
      begin
         st_next.oc_fault = 1'b0;
      end
      else if (cycle_start &&
         st_reg.oc_drv[motor_ctrl_pkg::CLEAR_ON_CYCLE_BIT])
      begin
         st_next.oc_fault = 1'b0;
      end

      // Overvoltage follows the comparator only while enabled
      st_next.ov_fault = SENSE.overvoltage &&
         st_reg.supply_rep[motor_ctrl_pkg::OV_ENABLE_BIT];

      // Sticky serial fault; set wins over the clear command
      if (SENSE.serial_fault)
      begin
         st_next.serial_fault = 1'b1;
      end
      else if (st_reg.fault_clear)
      begin
         st_next.serial_fault = 1'b0;
      end

      fault_any = st_reg.oc_fault || st_reg.ov_fault
         || (st_reg.serial_fault &&
            !st_reg.supply_rep[motor_ctrl_pkg::SERIAL_MASK_BIT])
         || (SENSE.thermal_warning &&
            st_reg.supply_rep[motor_ctrl_pkg::THERM_REP_BIT]);
      st_next.fault_out_n = !fault_any;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_reg.if_mode <= motor_ctrl_pkg::RST_IF_MODE;
         st_reg.supply_rep <= motor_ctrl_pkg::RST_SUPPLY_REP;
         st_reg.oc_drv <= motor_ctrl_pkg::RST_OC_DRV;
         st_reg.lock_code <= motor_ctrl_pkg::RST_WRITE_LOCK[2:0];
         st_reg.locked <= 1'b0;
         st_reg.fault_clear <= 1'b0;
         st_reg.deg_cnt <= '0;
         st_reg.oc_fault <= 1'b0;
         st_reg.retry_cnt <= '0;
         st_reg.ov_fault <= 1'b0;
         st_reg.serial_fault <= 1'b0;
         st_reg.pwm_prev <= 1'b0;
         st_reg.fault_out_n <= 1'b1;
         st_reg.rvalid <= 1'b0;
         st_reg.rdata <= 8'h00;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Fault shutdown shares the high-impedance path with the software force
   always_comb
   begin
      DRIVE_CFG.data_out_push_pull =
         st_reg.if_mode[motor_ctrl_pkg::DATA_OUT_DRIVE_BIT];
      DRIVE_CFG.slew_select =
         st_reg.if_mode[motor_ctrl_pkg::SLEW_LSB +: 2];
      DRIVE_CFG.sync_rectify =
         st_reg.if_mode[motor_ctrl_pkg::MODE_SYNC_BIT];
      DRIVE_CFG.digital_hall =
         st_reg.if_mode[motor_ctrl_pkg::MODE_DIGITAL_BIT];
      DRIVE_CFG.full_duty_40k =
         st_reg.supply_rep[motor_ctrl_pkg::FULL_DUTY_40K_BIT];
      DRIVE_CFG.ov_thresh_22v =
         st_reg.supply_rep[motor_ctrl_pkg::OV_THRESH_BIT];
      DRIVE_CFG.ov_protect_en =
         st_reg.supply_rep[motor_ctrl_pkg::OV_ENABLE_BIT];
      DRIVE_CFG.trip_level_13a =
         st_reg.oc_drv[motor_ctrl_pkg::TRIP_LEVEL_BIT];
      DRIVE_CFG.outputs_hiz = st_reg.oc_drv[motor_ctrl_pkg::HIZ_FORCE_BIT]
         || st_reg.oc_fault || st_reg.ov_fault;
   end

   assign REG_RDATA = st_reg.rdata;
   assign REG_RVALID = st_reg.rvalid;
   assign LOCKED = st_reg.locked;
   assign FAULT_CLEAR_PULSE = st_reg.fault_clear;
   assign OC_FAULT = st_reg.oc_fault;
   assign OV_FAULT = st_reg.ov_fault;
   assign SERIAL_FAULT = st_reg.serial_fault;
   assign FAULT_OUT_N = st_reg.fault_out_n;

endmodule : motor_driver_control_regs

// *** testbench/motor_ctrl_chk.sv ***
module motor_ctrl_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire motor_ctrl_pkg::reg_req_t REG_REQ,
   input wire motor_ctrl_pkg::sense_t SENSE,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire motor_ctrl_pkg::drive_cfg_t DRIVE_CFG,
   input wire logic LOCKED,
   input wire logic FAULT_CLEAR_PULSE,
   input wire logic OC_FAULT,
   input wire logic OV_FAULT,
   input wire logic SERIAL_FAULT,
   input wire logic FAULT_OUT_N
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   wire logic [7:0] d = REG_REQ.wdata;
   wire logic w3 = REG_REQ.wr && REG_REQ.addr == 4'h3;
   wire logic w4 = REG_REQ.wr && REG_REQ.addr == 4'h4 && !LOCKED;
   wire logic w5 = REG_REQ.wr && REG_REQ.addr == 4'h5 && !LOCKED;
   wire logic w6 = REG_REQ.wr && REG_REQ.addr == 4'h6 && !LOCKED;
   AST_UNLOCK: assert property (w3 && d[2:0] == 3'h3 |=> !LOCKED)
      else $error("unlock code ignored");
   AST_LOCK: assert property (w3 && d[2:0] == 3'h6 |=> LOCKED)
      else $error("lock code ignored");
   AST_KEEP: assert property (w3 && d[2:0] != 3'h3 && d[2:0] != 3'h6
      |=> LOCKED == $past(LOCKED)) else $error("lock state moved");
   AST_IGNORE: assert property (LOCKED && REG_REQ.wr && REG_REQ.addr == 4'h4
      |=> !FAULT_CLEAR_PULSE && $stable(DRIVE_CFG.slew_select))
      else $error("locked write taken");
   AST_CLR: assert property (FAULT_CLEAR_PULSE |-> $past(w4 && d[0]))
      else $error("clear pulse without command");
   AST_CFG4: assert property (w4 |=> DRIVE_CFG.slew_select == $past(d[4:3])
      && {DRIVE_CFG.data_out_push_pull, DRIVE_CFG.sync_rectify,
      DRIVE_CFG.digital_hall} == {$past(d[5]), $past(d[2:1])})
      else $error("interface fields wrong");
   AST_CFG5: assert property (w5 |=> {DRIVE_CFG.full_duty_40k,
      DRIVE_CFG.ov_thresh_22v, DRIVE_CFG.ov_protect_en} == $past(d[4:2]))
      else $error("supply fields wrong");
   AST_CFG6: assert property (w6 |=> DRIVE_CFG.trip_level_13a == $past(d[2])
      && (DRIVE_CFG.outputs_hiz || !$past(d[7]))) else $error("drive fields wrong");
   AST_OV: assert property ($past(RST_B) |-> OV_FAULT ==
      $past(SENSE.overvoltage && DRIVE_CFG.ov_protect_en)) else $error("ov flag wrong");
   AST_RDZ: assert property (REG_REQ.rd && REG_REQ.addr inside {4'h3, 4'h5}
      |=> REG_RVALID && !REG_RDATA[7] && (REG_RDATA[6:3] == 4'h0
      || $past(REG_REQ.addr) == 4'h5)) else $error("reserved bits read set");
endmodule : motor_ctrl_chk

bind motor_driver_control_regs motor_ctrl_chk chk (
   .CLK(CLK), .RST_B(RST_B), .REG_REQ(REG_REQ), .SENSE(SENSE),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .DRIVE_CFG(DRIVE_CFG),
   .LOCKED(LOCKED), .FAULT_CLEAR_PULSE(FAULT_CLEAR_PULSE),
   .OC_FAULT(OC_FAULT), .OV_FAULT(OV_FAULT), .SERIAL_FAULT(SERIAL_FAULT),
   .FAULT_OUT_N(FAULT_OUT_N)
);

// *** testbench/serial_host_model.sv ***
module serial_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output motor_ctrl_pkg::reg_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // One-cycle strobe, then an idle cycle so strobes never merge
   task automatic write(input logic [3:0] a, input logic [7:0] v);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge clk);
      req.wr = 1'b0;
   endtask : write
   task automatic read(input logic [3:0] a, output logic [7:0] v);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req.rd = 1'b0;
      v = rvalid ? rdata : 8'hxx;
   endtask : read
endmodule : serial_host_model

// *** testbench/motor_driver_control_regs_bench.sv ***
module motor_driver_control_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   motor_ctrl_pkg::reg_req_t req;
   motor_ctrl_pkg::sense_t sense = '0;
   motor_ctrl_pkg::drive_cfg_t cfg;
   logic [7:0] rdata, v;
   logic rvalid, locked, clr, oc, ov, ser, fault_n;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   motor_driver_control_regs #(.RETRY_SHORT_CYCLES(20),
      .RETRY_LONG_CYCLES(40)) uut (.CLK(clk), .RST_B(rst_b), .REG_REQ(req),
      .SENSE(sense), .REG_RDATA(rdata), .REG_RVALID(rvalid), .DRIVE_CFG(cfg),
      .LOCKED(locked), .FAULT_CLEAR_PULSE(clr), .OC_FAULT(oc), .OV_FAULT(ov),
      .SERIAL_FAULT(ser), .FAULT_OUT_N(fault_n));
   serial_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid),
      .req(req));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : cmp
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      host.read(a, v);
      cmp("readback", e, v);
   endtask : rd
   task automatic t_reset();
      rd(4'h3, 8'h00);
      rd(4'h4, 8'h80);
      rd(4'h5, 8'h46);
      rd(4'h6, 8'h10);
      rd(4'h7, 8'h00);
      cmp("pin", 8'h01, {7'h00, fault_n});
   endtask : t_reset
   task automatic t_fields();
      logic [7:0] w;
      for (int i = 0; i < 4; i++)
      begin
         w = {2'h0, i[0], i[1:0], i[1:0], 1'b0};
         host.write(4'h4, w);
         cmp("if cfg", {2'h0, i[0], i[1:0], i[1:0], 1'b0},
            {2'h0, cfg.data_out_push_pull, cfg.slew_select, cfg.sync_rectify,
            cfg.digital_hall, 1'b0});
         rd(4'h4, w);
         w = i[0] ? 8'hff : 8'h00;
         host.write(4'h5, w);
         rd(4'h5, w & 8'h7f);
         cmp("sup cfg", {5'h00, {3{i[0]}}}, {5'h00, cfg.full_duty_40k,
            cfg.ov_thresh_22v, cfg.ov_protect_en});
         host.write(4'h6, {i[0], 4'h0, i[0], 2'h0});
         cmp("drv cfg", {6'h00, i[0], i[0]},
            {6'h00, cfg.outputs_hiz, cfg.trip_level_13a});
      end
      host.write(4'h5, 8'h46);
   endtask : t_fields
   task automatic t_lock();
      for (int s = 0; s < 2; s++)
      begin
         host.write(4'h3, s ? 8'h03 : 8'h06);
         cmp("locked", {7'h00, !s[0]}, {7'h00, locked});
         host.write(4'h4, 8'h21);
         cmp("clr pulse", {7'h00, s[0]}, {7'h00, clr});
         rd(4'h4, s ? 8'h20 : 8'h3e);
         for (int c = 0; c < 8; c++)
         begin
            if (c != 3 && c != 6)
            begin
               host.write(4'h3, {5'h1f, c[2:0]});
               cmp("kept", {7'h00, !s[0]}, {7'h00, locked});
               rd(4'h3, {5'h00, c[2:0]});
            end
         end
      end
   endtask : t_lock
   task automatic t_pins();
      sense = '{thermal_warning: 1'b1, serial_fault: 1'b1, overvoltage: 1'b1,
         default: 1'b0};
      @(negedge clk);
      sense.serial_fault = 1'b0;
      sense.overvoltage = 1'b0;
      cmp("ov", 8'h01, {7'h00, ov});
      repeat (2) @(negedge clk);
      cmp("pin", 8'h01, {7'h00, fault_n});
      host.write(4'h5, 8'h45);
      repeat (2) @(negedge clk);
      cmp("pin", 8'h00, {7'h00, fault_n});
      host.write(4'h4, 8'h01);
      @(negedge clk);
      cmp("ser", 8'h00, {7'h00, ser});
      // Serial flag is gone, so only the thermal warning can pull the pin
      @(negedge clk);
      cmp("pin", 8'h00, {7'h00, fault_n});
      sense.thermal_warning = 1'b0;
      repeat (2) @(negedge clk);
      cmp("pin", 8'h01, {7'h00, fault_n});
      rd(4'h4, 8'h00);
   endtask : t_pins
   task automatic trip(input int n);
      sense.overcurrent = 1'b1;
      repeat (n) @(negedge clk);
      sense.overcurrent = 1'b0;
   endtask : trip
   task automatic t_oc(input logic [7:0] w, input logic e1, input logic e2);
      int n;
      // Filter length in cycles for the deglitch code carried by w
      case (w[5:4])
         2'h0: n = motor_ctrl_pkg::DEGLITCH_0_CYC;
         2'h1: n = motor_ctrl_pkg::DEGLITCH_1_CYC;
         2'h2: n = motor_ctrl_pkg::DEGLITCH_2_CYC;
         default: n = motor_ctrl_pkg::DEGLITCH_3_CYC;
      endcase
      host.write(4'h6, w);
      trip(n - 1);
      repeat (3) @(negedge clk);
      cmp("no trip", 8'h00, {7'h00, oc});
      trip(n + 2);
      cmp("trip", 8'h01, {7'h00, oc});
      repeat (25) @(negedge clk);
      cmp("held", {7'h00, e1}, {7'h00, oc});
      sense.pwm_in = 1'b1;
      repeat (30) @(negedge clk);
      cmp("later", {7'h00, e2}, {7'h00, oc});
      sense.pwm_in = 1'b0;
      host.write(4'h4, 8'h01);
      @(negedge clk);
      cmp("cleared", 8'h00, {7'h00, oc});
   endtask : t_oc
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         num_errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_fields();
      t_lock();
      t_pins();
      t_oc(8'h00, 1'b1, 1'b1);
      t_oc(8'h11, 1'b0, 1'b0);
      t_oc(8'h39, 1'b1, 1'b0);
      t_oc(8'h60, 1'b1, 1'b0);
      finish_test();
   end
endmodule : motor_driver_control_regs_bench
